// ---- hdl/cscr_pkg.sv ----
// Package for the clock synthesizer control register bank: offsets, fields, resets, carrier structs.
package cscr_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] CSCR_IDX_INPUT_CONTROL   = 8'h00;
  localparam logic [7:0] CSCR_IDX_LOOP_CONTROL    = 8'h01;
  localparam logic [7:0] CSCR_IDX_FB_DIV_LOW      = 8'h02;
  localparam logic [7:0] CSCR_IDX_FB_DIV_HIGH     = 8'h03;
  localparam logic [7:0] CSCR_IDX_PHASE_OFFSET    = 8'h04;
  localparam logic [7:0] CSCR_IDX_PHASE_RES       = 8'h05;
  localparam logic [7:0] CSCR_IDX_OUTPUT_ENABLES  = 8'h06;
  localparam logic [7:0] CSCR_IDX_REF_DIVIDER     = 8'h07;
  localparam logic [7:0] CSCR_IDX_RESET_COMMAND   = 8'h08;
  localparam logic [7:0] CSCR_IDX_DEVICE_VERSION  = 8'h10;
  localparam logic [7:0] CSCR_IDX_DEVICE_REVISION = 8'h11;
  localparam logic [7:0] CSCR_IDX_LOCK_STATUS     = 8'h12;

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CSCR_RST_INPUT_CONTROL   = 8'h41;
  localparam logic [7:0] CSCR_RST_LOOP_CONTROL    = 8'h00;
  localparam logic [7:0] CSCR_RST_FB_DIV_LOW      = 8'hff;
  localparam logic [7:0] CSCR_RST_FB_DIV_HIGH     = 8'h0f;
  localparam logic [7:0] CSCR_RST_PHASE_OFFSET    = 8'h00;
  localparam logic [7:0] CSCR_RST_PHASE_RES       = 8'h03;
  localparam logic [7:0] CSCR_RST_OUTPUT_ENABLES  = 8'h00;
  localparam logic [7:0] CSCR_RST_REF_DIVIDER     = 8'h80;
  localparam logic [7:0] CSCR_MASK_LOOP_CONTROL   = 8'h37;
  localparam logic [7:0] CSCR_MASK_FB_DIV_HIGH    = 8'h0f;
  localparam logic [7:0] CSCR_MASK_PHASE_OFFSET   = 8'hbf;
  localparam logic [7:0] CSCR_MASK_PHASE_RES      = 8'h03;
  localparam logic [7:0] CSCR_MASK_ALL            = 8'hff;

  // ----------------------------------------------------------------
  // Field positions and command codes
  // ----------------------------------------------------------------
  localparam int CSCR_BIT_PUMP_ALWAYS_ON = 0;
  localparam int CSCR_BIT_PUMP_HOLD_INPUT_POLARITY = 1;
  localparam int CSCR_BIT_REF_EDGE       = 2;
  localparam int CSCR_BIT_FB_EDGE        = 3;
  localparam int CSCR_BIT_FB_SELECT      = 4;
  localparam int CSCR_BIT_FUNC_SELECT    = 5;
  localparam int CSCR_BIT_LOCK_OUT_EN    = 6;
  localparam int CSCR_BIT_REF_OUT_EN     = 7;
  localparam int CSCR_BIT_FILTER_SEL     = 7;
  localparam int CSCR_BIT_HALF_INVERT    = 5;
  localparam int CSCR_BIT_INPUT_SEL      = 7;
  localparam int CSCR_BIT_LOCKED         = 1;
  localparam logic [3:0] CSCR_CMD_PHASE_RESET = 4'ha;
  localparam logic [3:0] CSCR_CMD_LOOP_RESET  = 4'h5;
  localparam logic [3:0] CSCR_FB_DIV_OFFSET   = 4'h8;
  localparam logic [1:0] CSCR_RES_RESERVED    = 2'b10;
  localparam int CSCR_SYNC_PULSES_TO_RESUME   = 2;

  // Register write carrier from the serial protocol engine.
  typedef struct packed {
    logic       en;
    logic [7:0] idx;
    logic [7:0] data;
  } cscr_wr_s;

  // Working (double-buffered) loop settings.
  typedef struct packed {
    logic [2:0]  pump_current;
    logic [1:0]  oscillator_divide;
    logic [11:0] loop_divider;
  } cscr_loop_s;

endpackage

// ---- hdl/cscr_regs.sv ----
// Control and status register bank of the clock synthesizer.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module cscr_regs
  import cscr_pkg::*;
#(
  parameter logic [7:0] VERSION_CODE  = 8'h5a,  // Arbitrary identification value.
  parameter logic [7:0] REVISION_CODE = 8'h03   // Arbitrary identification value.
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire cscr_wr_s    wr_i,
  input  wire logic [7:0]  rd_idx_i,
  output logic      [7:0]  rd_data_o,
  input  wire logic        pump_hold_input_i,
  input  wire logic        sync_pulse_i,
  input  wire logic        pll_locked_i,
  input  wire logic        sync_conditioned_i,
  input  wire logic        osc_tick_i,
  output logic             pump_enable_o,
  output logic             ref_edge_falling_o,
  output logic             fb_edge_falling_o,
  output logic             fb_select_external_o,
  output logic             func_select_input_o,
  output logic             lock_ref_o,
  output cscr_loop_s       loop_working_o,
  output logic             loop_reset_o,
  output logic [5:0]       phase_delay_offset_o,
  output logic             filter_internal_o,
  output logic [6:0]       phase_delay_elements_o,
  output logic             phase_reset_o,
  output logic [4:0]       output_enable_o,
  output logic             half_clock_invert_o,
  output logic [3:0]       full_clock_scale_o,
  output logic             input_select_osc_o,
  output logic             ref_divided_o
);

  // ----------------------------------------------------------------
  // Host-visible registers, working resolution copy and command strobes
  // ----------------------------------------------------------------
  logic [7:0] input_control_r;
  logic [7:0] loop_control_r;
  logic [7:0] fb_div_low_r;
  logic [7:0] fb_div_high_r;
  logic [7:0] phase_offset_r;
  logic [7:0] phase_res_r;
  logic [7:0] output_enables_r;
  logic [7:0] ref_divider_r;
  logic [1:0] phase_res_work_r;
  logic       phase_cmd;
  logic       loop_cmd;

  // Masked write data, so reserved bits never store a written one.
  function automatic logic [7:0] wr_val(input logic [7:0] d, input logic [7:0] m);
    return d & m;
  endfunction

  // Write strobe decode for one register index.
  function automatic logic wr_hit(input cscr_wr_s w, input logic [7:0] idx);
    return w.en && (w.idx == idx);
  endfunction

  // Reset command decode: both nibbles act independently in one write.
  // phase command decode
  assign phase_cmd = wr_hit(wr_i, CSCR_IDX_RESET_COMMAND) && (wr_i.data[3:0] == CSCR_CMD_PHASE_RESET);
  assign loop_cmd  = wr_hit(wr_i, CSCR_IDX_RESET_COMMAND) && (wr_i.data[7:4] == CSCR_CMD_LOOP_RESET);

  // Register writes; read-only indices are simply not decoded.
  // masks and ignores
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      input_control_r  <= CSCR_RST_INPUT_CONTROL;
      loop_control_r   <= CSCR_RST_LOOP_CONTROL;
      fb_div_low_r     <= CSCR_RST_FB_DIV_LOW;
      fb_div_high_r    <= CSCR_RST_FB_DIV_HIGH;
      phase_offset_r   <= CSCR_RST_PHASE_OFFSET;
      phase_res_r      <= CSCR_RST_PHASE_RES;
      output_enables_r <= CSCR_RST_OUTPUT_ENABLES;
      ref_divider_r    <= CSCR_RST_REF_DIVIDER;
    end else begin
      if (wr_hit(wr_i, CSCR_IDX_INPUT_CONTROL)) begin
        input_control_r <= wr_val(wr_i.data, CSCR_MASK_ALL);
      end
      if (wr_hit(wr_i, CSCR_IDX_LOOP_CONTROL)) begin
        loop_control_r <= wr_val(wr_i.data, CSCR_MASK_LOOP_CONTROL);
      end
      if (wr_hit(wr_i, CSCR_IDX_FB_DIV_LOW)) begin
        fb_div_low_r <= wr_val(wr_i.data, CSCR_MASK_ALL);
      end
      if (wr_hit(wr_i, CSCR_IDX_FB_DIV_HIGH)) begin
        fb_div_high_r <= wr_val(wr_i.data, CSCR_MASK_FB_DIV_HIGH);
      end
      if (wr_hit(wr_i, CSCR_IDX_PHASE_OFFSET)) begin
        phase_offset_r <= wr_val(wr_i.data, CSCR_MASK_PHASE_OFFSET);
      end
      if (wr_hit(wr_i, CSCR_IDX_PHASE_RES)) begin
        phase_res_r <= wr_val(wr_i.data, CSCR_MASK_PHASE_RES);
      end
      if (wr_hit(wr_i, CSCR_IDX_OUTPUT_ENABLES)) begin
        output_enables_r <= wr_val(wr_i.data, CSCR_MASK_ALL);
      end
      if (wr_hit(wr_i, CSCR_IDX_REF_DIVIDER)) begin
        ref_divider_r <= wr_val(wr_i.data, CSCR_MASK_ALL);
      end
    end
  end

  // ----------------------------------------------------------------
  // Double-buffered working copies
  // ----------------------------------------------------------------
  // The working copy takes the programmed value, not the command write itself,
  // so the host may stage several registers and switch the loop at once.
  // loop copy load
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      loop_working_o.pump_current      <= CSCR_RST_LOOP_CONTROL[2:0];
      loop_working_o.oscillator_divide <= CSCR_RST_LOOP_CONTROL[5:4];
      loop_working_o.loop_divider      <= {CSCR_RST_FB_DIV_HIGH[3:0], CSCR_RST_FB_DIV_LOW};
    end else if (loop_cmd) begin
      loop_working_o.pump_current      <= loop_control_r[2:0];
      loop_working_o.oscillator_divide <= loop_control_r[5:4];
      loop_working_o.loop_divider      <= {fb_div_high_r[3:0], fb_div_low_r};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      phase_res_work_r <= CSCR_RST_PHASE_RES[1:0];
    end else if (phase_cmd) begin
      phase_res_work_r <= phase_res_r[1:0];
    end
  end

  // Command pulses to the loop and delay line, one cycle after the write.
  // phase reset pulse
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      phase_reset_o <= 1'b0;
      loop_reset_o  <= 1'b0;
    end else begin
      phase_reset_o <= phase_cmd;
      loop_reset_o  <= loop_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Decoded settings
  // ----------------------------------------------------------------
  // input control, phase offset, output enable and input select field decode
  assign ref_edge_falling_o   = input_control_r[CSCR_BIT_REF_EDGE];
  assign fb_edge_falling_o    = input_control_r[CSCR_BIT_FB_EDGE];
  assign fb_select_external_o = input_control_r[CSCR_BIT_FB_SELECT];
  assign func_select_input_o  = input_control_r[CSCR_BIT_FUNC_SELECT];
  assign phase_delay_offset_o = phase_offset_r[5:0];
  assign filter_internal_o    = phase_offset_r[CSCR_BIT_FILTER_SEL];
  assign output_enable_o      = output_enables_r[4:0];
  assign half_clock_invert_o  = output_enables_r[CSCR_BIT_HALF_INVERT];
  // full clock scaler, one-hot shift gives 1, 2, 4 or 8.
  assign full_clock_scale_o   = 4'h1 << output_enables_r[7:6];
  assign input_select_osc_o   = ref_divider_r[CSCR_BIT_INPUT_SEL];
  // pump current code passed raw; divider offset is added by the loop.

  // element count decode, reserved code reported as zero elements.
  always_comb begin
    unique case (phase_res_work_r)
      2'b00:   phase_delay_elements_o = 7'h10;
      2'b01:   phase_delay_elements_o = 7'h20;
      2'b11:   phase_delay_elements_o = 7'h40;
      default: phase_delay_elements_o = 7'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Charge pump hold
  // ----------------------------------------------------------------
  // Unless the always-on bit is set, the hold pin clears the pump at once (combinational); resumption waits for the
  // second sync pulse after release so a half-measured line never corrupts the loop.
  logic       hold_active;
  logic       resume_ok_r;
  logic [1:0] sync_count_r;

  // polarity applied
  // The pin is a pump enable, so the hold is the pin's inactive level.
  // With polarity 0 a low pin holds the pump; with polarity 1 a high pin does.
  assign hold_active = (pump_hold_input_i ^ input_control_r[CSCR_BIT_PUMP_HOLD_INPUT_POLARITY]) ? 1'b0 : 1'b1;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      resume_ok_r  <= 1'b1;
      sync_count_r <= 2'd0;
    end else if (hold_active) begin
      resume_ok_r  <= 1'b0;
      sync_count_r <= 2'd0;
    end else if (!resume_ok_r && sync_pulse_i) begin
      if (sync_count_r == 2'(CSCR_SYNC_PULSES_TO_RESUME - 1)) begin
        resume_ok_r <= 1'b1;
      end
      sync_count_r <= sync_count_r + 2'd1;
    end
  end

  assign pump_enable_o = input_control_r[CSCR_BIT_PUMP_ALWAYS_ON] | (!hold_active && resume_ok_r);

  // ----------------------------------------------------------------
  // Reference divider
  // ----------------------------------------------------------------
  // Counts oscillator ticks: high for one tick, low for modulus plus one ticks.
  // A modulus of zero is reserved; it simply yields one high and one low tick.
  logic [6:0] ref_count_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ref_divided_o <= 1'b0;
      ref_count_r   <= 7'd0;
    end else if (osc_tick_i) begin
      if (ref_divided_o) begin
        ref_divided_o <= 1'b0;
        ref_count_r   <= ref_divider_r[6:0];
      end else if (ref_count_r == 7'd0) begin
        ref_divided_o <= 1'b1;
      end else begin
        ref_count_r <= ref_count_r - 7'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock/reference status pin
  // ----------------------------------------------------------------
  // status pin select
  always_comb begin
    unique case ({input_control_r[CSCR_BIT_REF_OUT_EN], input_control_r[CSCR_BIT_LOCK_OUT_EN]})
      2'b01:   lock_ref_o = pll_locked_i;
      2'b11:   lock_ref_o = ref_divider_r[CSCR_BIT_INPUT_SEL] ? ref_divided_o
                            : (sync_conditioned_i ^ input_control_r[CSCR_BIT_REF_EDGE]);
      default: lock_ref_o = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Registered read data; write-only and unmapped indices read as zero.
  // identity reads
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rd_data_o <= 8'h00;
    end else begin
      unique case (rd_idx_i)
        CSCR_IDX_INPUT_CONTROL:   rd_data_o <= input_control_r;
        CSCR_IDX_LOOP_CONTROL:    rd_data_o <= loop_control_r;
        CSCR_IDX_FB_DIV_LOW:      rd_data_o <= fb_div_low_r;
        CSCR_IDX_FB_DIV_HIGH:     rd_data_o <= fb_div_high_r;
        CSCR_IDX_PHASE_OFFSET:    rd_data_o <= phase_offset_r;
        CSCR_IDX_PHASE_RES:       rd_data_o <= phase_res_r;
        CSCR_IDX_OUTPUT_ENABLES:  rd_data_o <= output_enables_r;
        CSCR_IDX_REF_DIVIDER:     rd_data_o <= ref_divider_r;
        CSCR_IDX_DEVICE_VERSION:  rd_data_o <= VERSION_CODE;
        CSCR_IDX_DEVICE_REVISION: rd_data_o <= REVISION_CODE;
        CSCR_IDX_LOCK_STATUS:     rd_data_o <= {6'h00, pll_locked_i, 1'b0};
        default:                  rd_data_o <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- sim/cscr_regs_sva.sv ----
// Port-level checker of the clock synthesizer register bank.
`timescale 1ns/1ps
`default_nettype none
module cscr_regs_sva
  import cscr_pkg::*;
#(
  parameter logic [7:0] VERSION_CODE  = 8'h5a,  // Arbitrary identification value.
  parameter logic [7:0] REVISION_CODE = 8'h03   // Arbitrary identification value.
) (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire cscr_wr_s   wr_i,
  input wire logic [7:0] rd_idx_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       pll_locked_i,
  input wire logic       osc_tick_i,
  input wire logic       pump_enable_o,
  input wire cscr_loop_s loop_working_o,
  input wire logic       loop_reset_o,
  input wire logic [6:0] phase_delay_elements_o,
  input wire logic       phase_reset_o,
  input wire logic [3:0] full_clock_scale_o,
  input wire logic       ref_divided_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Command decode seen at the write port; nibbles act independently.
  logic loop_cmd;
  logic phase_cmd;
  assign loop_cmd  = wr_i.en && wr_i.idx == CSCR_IDX_RESET_COMMAND && wr_i.data[7:4] == CSCR_CMD_LOOP_RESET;
  assign phase_cmd = wr_i.en && wr_i.idx == CSCR_IDX_RESET_COMMAND && wr_i.data[3:0] == CSCR_CMD_PHASE_RESET;
  property p_loop_cmd; loop_reset_o == $past(loop_cmd); endproperty
  a_loop_cmd: assert property (p_loop_cmd) else $error("loop reset pulse wrong");
  property p_phase_cmd; phase_reset_o == $past(phase_cmd); endproperty
  a_phase_cmd: assert property (p_phase_cmd) else $error("phase reset pulse wrong");
  property p_loop_hold; $changed(loop_working_o) |-> loop_reset_o; endproperty
  a_loop_hold: assert property (p_loop_hold) else $error("loop copy moved without command");
  property p_res_hold; $changed(phase_delay_elements_o) |-> phase_reset_o; endproperty
  a_res_hold: assert property (p_res_hold) else $error("resolution moved without command");
  property p_res_code; phase_delay_elements_o inside {7'd0, 7'd16, 7'd32, 7'd64}; endproperty
  a_res_code: assert property (p_res_code) else $error("element count illegal");
  property p_scale; $onehot(full_clock_scale_o) && full_clock_scale_o != 4'h0; endproperty
  a_scale: assert property (p_scale) else $error("clock scale illegal");
  property p_lock_rd; rd_idx_i == CSCR_IDX_LOCK_STATUS |=> rd_data_o == {6'h00, $past(pll_locked_i), 1'b0}; endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("lock status read wrong");
  property p_cmd_rd; rd_idx_i == CSCR_IDX_RESET_COMMAND |=> rd_data_o == 8'h00; endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("write-only register read nonzero");
  property p_id_rd; rd_idx_i == CSCR_IDX_DEVICE_VERSION ##1 rd_idx_i == CSCR_IDX_DEVICE_REVISION
    |-> rd_data_o == VERSION_CODE ##1 rd_data_o == REVISION_CODE; endproperty
  a_id_rd: assert property (p_id_rd) else $error("identity read wrong");
  property p_ref_high; ref_divided_o && osc_tick_i |=> !ref_divided_o; endproperty
  a_ref_high: assert property (p_ref_high) else $error("reference high too long");
  property p_ref_quiet; !osc_tick_i |=> $stable(ref_divided_o); endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("reference moved without tick");
  c_loop: cover property (loop_reset_o);
  c_phase: cover property (phase_reset_o);
  c_pump: cover property ($rose(pump_enable_o));
endmodule

bind cscr_regs cscr_regs_sva #(.VERSION_CODE(VERSION_CODE), .REVISION_CODE(REVISION_CODE)) i_sva (
  .sys_clk_i, .rstn_i, .wr_i, .rd_idx_i, .rd_data_o, .pll_locked_i, .osc_tick_i, .pump_enable_o,
  .loop_working_o, .loop_reset_o, .phase_delay_elements_o, .phase_reset_o, .full_clock_scale_o,
  .ref_divided_o
);
`default_nettype wire

// ---- sim/cscr_host_model.sv ----
// Serial host model that issues register writes and reads.
`timescale 1ns/1ps
`default_nettype none
module cscr_host_model
  import cscr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] rd_data_i,
  output var  cscr_wr_s   wr_o,
  output var  logic [7:0] rd_idx_o
);
  initial begin
    wr_o = '0;
    rd_idx_o = 8'h00;
  end
  // offset below count: the host keeps the offset under the smallest element count.
  task automatic write(input logic [7:0] idx, input logic [7:0] data);
    @(negedge sys_clk_i);
    wr_o = {1'b1, idx, (idx == CSCR_IDX_PHASE_OFFSET) ? {data[7:4] & 4'hc, data[3:0]} : data};
    @(negedge sys_clk_i);
    // Idle lines show the inverse so that no stale value is mistaken for a write.
    wr_o = {1'b0, ~wr_o.idx, ~wr_o.data};
  endtask
  task automatic read(input logic [7:0] idx, output logic [7:0] data);
    @(negedge sys_clk_i);
    rd_idx_o = idx;
    @(negedge sys_clk_i);
    data = rd_data_i;
  endtask
endmodule
`default_nettype wire

// ---- sim/cscr_regs_tb.sv ----
// Self-checking bench for the clock synthesizer register bank.
`timescale 1ns/1ps
`default_nettype none
module cscr_regs_tb;
  import cscr_pkg::*;
  localparam logic [7:0] VER = 8'h3c;  // Arbitrary identification value.
  localparam logic [7:0] REV = 8'h07;  // Arbitrary identification value.
  logic clk, rstn, hold, sync, lock, cond, tick, pump, refe, fbe, fbs, funs, lref, lrst, filt, prst, hinv, isel, refd;
  cscr_wr_s wr;
  cscr_loop_s lw;
  logic [7:0] rd_idx, rd_data, a, d, g;
  logic [5:0] pofs;
  logic [6:0] elem;
  logic [4:0] oe;
  logic [3:0] scl;
  logic [31:0] r;
  int fails, checks, seed, n;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  cscr_regs #(.VERSION_CODE(VER), .REVISION_CODE(REV)) i_dut (.sys_clk_i(clk), .rstn_i(rstn), .wr_i(wr),
    .rd_idx_i(rd_idx), .rd_data_o(rd_data), .pump_hold_input_i(hold), .sync_pulse_i(sync), .pll_locked_i(lock),
    .sync_conditioned_i(cond), .osc_tick_i(tick), .pump_enable_o(pump), .ref_edge_falling_o(refe),
    .fb_edge_falling_o(fbe), .fb_select_external_o(fbs), .func_select_input_o(funs), .lock_ref_o(lref),
    .loop_working_o(lw), .loop_reset_o(lrst), .phase_delay_offset_o(pofs), .filter_internal_o(filt),
    .phase_delay_elements_o(elem), .phase_reset_o(prst), .output_enable_o(oe), .half_clock_invert_o(hinv),
    .full_clock_scale_o(scl), .input_select_osc_o(isel), .ref_divided_o(refd));
  cscr_host_model i_host (.sys_clk_i(clk), .rd_data_i(rd_data), .wr_o(wr), .rd_idx_o(rd_idx));
  function automatic logic [7:0] rst_val(input logic [7:0] i);
    case (i)
      8'h00: return 8'h41;
      8'h02: return 8'hff;
      8'h03: return 8'h0f;
      8'h05: return 8'h03;
      8'h07: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction
  // Reserved bits read zero; the host also clears offset bits 5-4.
  function automatic logic [7:0] mask(input logic [7:0] i, input logic [7:0] v);
    case (i)
      8'h01: return v & 8'h37;
      8'h03: return v & 8'h0f;
      8'h04: return v & 8'h8f;
      8'h05: return v & 8'h03;
      default: return v;
    endcase
  endfunction
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] i, input logic [7:0] exp);
    i_host.read(i, g);
    chk({12'h000, g}, {12'h000, exp});
  endtask
  task automatic do_reset;
    @(negedge clk) rstn = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
  endtask
  task automatic pulse_sync;
    @(negedge clk) sync = 1'b1;
    @(negedge clk) sync = 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict;
  end
  initial begin
    seed = 88; rstn = 1'b0; hold = 1'b0; sync = 1'b0; lock = 1'b0; cond = 1'b0; tick = 1'b0;
    do_reset;
    for (n = 0; n < 8; n++) chk_rd(n[7:0], rst_val(n[7:0]));
    chk({pump, elem, lw[11:0]}, {1'b1, 7'd64, 12'hfff});
    chk_rd(8'h10, VER);
    chk_rd(8'h11, REV);
    lock = 1'b1;
    chk_rd(8'h12, 8'h02);
    chk_rd(8'h08, 8'h00);
    chk_rd(8'h0f, 8'h00);
    // Random writes, each read back; writes to 00, 04, 06 and 07 are also traced to their field outputs.
    for (n = 0; n < 40; n++) begin
      r = $random(seed);
      a = {5'h00, r[2:0]};
      d = r[15:8];
      i_host.write(a, d);
      chk_rd(a, mask(a, d));
      case (a)
        8'h00: chk(d[5:2], {funs, fbs, fbe, refe});
        8'h04: chk({pofs, filt}, {2'b00, d[3:0], d[7]});
        8'h06: chk({oe, hinv, scl}, {d[4:0], d[5], 4'(1 << d[7:6])});
        8'h07: chk(isel, d[7]);
        default: ;
      endcase
    end
    // Staged loop and resolution settings wait for their commands; second reset mid-run.
    do_reset;
    i_host.write(8'h01, 8'hf5);
    i_host.write(8'h02, 8'h34);
    i_host.write(8'h03, 8'h0a);
    i_host.write(8'h05, 8'h00);
    chk({elem, lw[12:0]}, {7'd64, 13'h0fff});
    i_host.write(8'h08, 8'h50);
    chk({lrst, prst, lw}, {2'b10, 3'd5, 2'd3, 12'ha34});
    i_host.write(8'h08, 8'h0a);
    chk({lrst, prst, elem}, {2'b01, 7'd16});
    i_host.write(8'h05, 8'h02);
    i_host.write(8'h08, 8'h5a);
    chk({lrst, prst, elem}, {2'b11, 7'd0});
    i_host.write(8'h05, 8'h01);
    i_host.write(8'h08, 8'h3a);
    chk({lrst, prst, elem}, {2'b01, 7'd32});
    i_host.write(8'h10, 8'hff);
    i_host.write(8'h11, 8'hff);
    chk_rd(8'h10, VER);
    chk_rd(8'h11, REV);
    // Hold pin in both polarities; sync pulses during hold must not count.
    for (n = 0; n < 2; n++) begin
      @(negedge clk) hold = n[0];
      i_host.write(8'h00, {6'h10, n[0], 1'b0});
      chk(pump, 1'b0);
      pulse_sync;
      @(negedge clk) hold = ~n[0];
      pulse_sync;
      chk(pump, 1'b0);
      pulse_sync;
      chk(pump, 1'b1);
    end
    // Status pin codes, then the divided reference on it.
    cond = 1'b0;
    i_host.write(8'h07, 8'h02);
    i_host.write(8'h00, 8'h01);
    chk(lref, 1'b0);
    i_host.write(8'h00, 8'h81);
    chk(lref, 1'b0);
    i_host.write(8'h00, 8'h41);
    chk(lref, 1'b1);
    @(negedge clk) lock = 1'b0;
    #1 chk(lref, 1'b0);
    i_host.write(8'h00, 8'hc5);
    chk(lref, 1'b1);
    i_host.write(8'h07, 8'h82);
    tick = 1'b1;
    n = 0;
    while (refd !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    chk({refd, lref}, 2'b00);
    repeat (2) @(negedge clk);
    chk({refd, lref}, 2'b00);
    @(negedge clk);
    chk({refd, lref}, 2'b11);
    print_verdict;
  end
endmodule
`default_nettype wire
